/* testbench/pin_host_model.sv */
// Host side of the test pins: drives the pins the block leaves free.
// Assumes pin levels settle within one clock.
`timescale 1ns/1ps
`default_nettype none
module pin_host_model (
  // Block pins
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic host_serial_active,
  // Host levels
  input wire logic [5:0] ext_val,
  // Resolved levels and misuse flag
  output logic [5:0] pin_lvl,
  output logic misuse
);
  assign misuse = host_serial_active && (pin_oe[5:4] != 2'b00);
  assign pin_lvl = (pin_out & pin_oe) | (ext_val & ~pin_oe);
endmodule // pin_host_model
`default_nettype wire

/* testbench/test_port_and_self_check_field_control_tb_top.sv */
// Self-checking bench for the test-page control block.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`default_nettype none
module test_port_and_self_check_field_control_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic host_serial_active = 1'b1;
  logic [255:0] probe_buses;
  logic checksum_calc_command = 1'b0;
  logic [5:0] ext_val = 6'h2a;
  logic [5:0] pin_in, pin_out, pin_oe;
  logic [7:0] rdata;
  logic uart_aux_tx_en, uart_data_req_en, rx_nonlinear, misuse;
  logic [11:0] sof_high_len, sof_low_len, eof_low_len, hi, lo;
  logic self_test_enabled, self_test_start;
  int failures = 0;
  int n_compared = 0;
  always #2.5 clk = ~clk;
  initial for (int n = 0; n < 32; n++) probe_buses[8*n +: 8] = 8'(n * 9 + 5);
  test_port_ctrl test_port_ctrl_i (.clk, .resetn, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .host_serial_active, .probe_buses, .checksum_calc_command, .pin_in, .pin_out, .pin_oe,
    .uart_aux_tx_en, .uart_data_req_en, .rx_nonlinear, .sof_high_len, .sof_low_len,
    .eof_low_len, .self_test_enabled, .self_test_start);
  pin_host_model pin_host_model_i (.pin_out, .pin_oe, .host_serial_active, .ext_val,
    .pin_lvl(pin_in), .misuse);
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic exp);
    @(posedge clk);
    checksum_calc_command <= 1'b1;
    @(posedge clk);
    checksum_calc_command <= 1'b0;
    #1;
    chk(self_test_start, exp);
  endtask
  task automatic close_out;
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd(6'h33, 8'h80);
    rd(6'h34, 8'h00);
    rd(6'h36, 8'h40);
    rd(6'h3e, 8'h01);
    rd(6'h32, 8'h00);
    rd(6'h10, 8'h00);
    chk({uart_aux_tx_en, uart_data_req_en, rx_nonlinear, self_test_enabled}, 4'he);
    chk(sof_high_len, 12'h180);
    chk(eof_low_len, 12'h580);
    wr(6'h33, 8'h1f);
    wr(6'h34, 8'hab);
    settle;
    rd(6'h33, 8'h1e);
    chk({uart_aux_tx_en, uart_data_req_en}, 2'b00);
    chk(pin_oe, 6'h0f);
    chk(pin_out, 6'h15);
    rd(6'h34, 8'hca);
    chk(misuse, 1'b0);
    wr(6'h34, 8'h2b);
    settle;
    rd(6'h34, 8'h2a);
    chk(pin_out, 6'h02);
    wr(6'h34, 8'hab);
    @(posedge clk);
    host_serial_active <= 1'b0;
    settle;
    rd(6'h34, 8'haa);
    chk(pin_out, 6'h02);
    @(posedge clk);
    host_serial_active <= 1'b1;
    settle;
    rd(6'h34, 8'hca);
    for (int s = 5; s < 37; s += 26) begin
      wr(6'h32, 8'(s));
      settle;
      rd(6'h35, 8'(s * 9 + 5));
    end
    for (int i = 0; i < 4; i++) begin
      wr(6'h3e, 8'(i & 1));
      wr(6'h36, 8'((i & 2) << 3));
      settle;
      hi = (i == 3) ? 12'h108 : (i == 1) ? 12'h180 : 12'h100;
      lo = (i == 3) ? 12'h578 : (i == 1) ? 12'h580 : 12'h500;
      chk(sof_high_len, hi);
      chk(sof_low_len, lo);
      chk(eof_low_len, lo);
      chk(rx_nonlinear, 1'b0);
    end
    wr(6'h36, 8'hff);
    rd(6'h36, 8'h5f);
    pulse(1'b0);
    wr(6'h36, 8'h49);
    settle;
    chk(self_test_enabled, 1'b1);
    pulse(1'b1);
    wr(6'h36, 8'h48);
    settle;
    pulse(1'b0);
    wr(6'h36, 8'h40);
    settle;
    chk(self_test_enabled, 1'b0);
    close_out;
  end
endmodule // test_port_and_self_check_field_control_tb_top
`default_nettype wire

/* testbench/test_port_ctrl_asserts.sv */
// Assertions on the ports of the test-page control block.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module test_port_ctrl_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  // Watched signals
  input wire logic checksum_calc_command,
  input wire logic [5:0] pin_oe,
  input wire logic uart_aux_tx_en,
  input wire logic rx_nonlinear,
  input wire logic [11:0] sof_high_len,
  input wire logic [11:0] sof_low_len,
  input wire logic [11:0] eof_low_len,
  input wire logic self_test_enabled,
  input wire logic self_test_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] wd1;
  logic [7:0] wd2;
  logic [7:0] wd3;
  logic mapped;
  assign mapped = (addr >= 6'h32 && addr <= 6'h36) || addr == 6'h3e;
  // Write data delayed to line up with derived outputs.
  always_ff @(posedge clk) begin
    wd1 <= wdata;
    wd2 <= wd1;
    wd3 <= wd2;
  end
  property p_unmapped;
    rd_en && !mapped |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_resv;
    rd_en && addr == 6'h36 |=> rdata[7] == 1'b0 && rdata[5] == 1'b0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");
  property p_uart;
    wr_en && addr == 6'h33 |-> ##2 uart_aux_tx_en == wd2[7];
  endproperty
  a_uart: assert property (p_uart) else $error("uart line enable wrong");
  property p_oe;
    wr_en && addr == 6'h33 |-> ##3 pin_oe == wd3[6:1];
  endproperty
  a_oe: assert property (p_oe) else $error("pin driver enables wrong");
  property p_amp;
    wr_en && addr == 6'h36 |-> ##2 rx_nonlinear == wd2[6];
  endproperty
  a_amp: assert property (p_amp) else $error("receiver mode wrong");
  property p_st_en;
    wr_en && addr == 6'h36 |-> ##2 self_test_enabled == (wd2[3:0] == 4'h9);
  endproperty
  a_st_en: assert property (p_st_en) else $error("self-test enable wrong");
  property p_st_go;
    checksum_calc_command && self_test_enabled && !$past(wr_en) |=> self_test_start;
  endproperty
  a_st_go: assert property (p_st_go) else $error("self-test did not start");
  property p_st_stray;
    self_test_start |-> $past(checksum_calc_command);
  endproperty
  a_st_stray: assert property (p_st_stray) else $error("stray self-test start");
  property p_len;
    sof_low_len == eof_low_len && ((sof_high_len == 12'h108 && sof_low_len == 12'h578)
      || (sof_high_len == 12'h180 && sof_low_len == 12'h580)
      || (sof_high_len == 12'h100 && sof_low_len == 12'h500));
  endproperty
  a_len: assert property (p_len) else $error("delimiter lengths wrong");
endmodule // test_port_ctrl_asserts
bind test_port_ctrl test_port_ctrl_asserts test_port_ctrl_asserts_i (.clk, .resetn, .addr,
  .wdata, .wr_en, .rd_en, .rdata, .checksum_calc_command, .pin_oe, .uart_aux_tx_en,
  .rx_nonlinear, .sof_high_len, .sof_low_len, .eof_low_len, .self_test_enabled,
  .self_test_start);
`default_nettype wire

/* verilog/pin_io_block.sv */
// Driver for the six test-port data pins, one slice per pin.
// Assumes pin inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pin_io_block (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control side
  pins_if.pins ctl,
  // Pins, D6 down to D1
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe
);

  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
    logic [5:0] level;
  } pin_state_t;

  pin_state_t cur_reg;
  pin_state_t cur_next;
  logic [5:0] out_w;

  // One slice per pin picks the level to drive.
  for (genvar i = 0; i < 6; i++) begin : g_pin
    assign out_w[i] = ctl.io_mode ? ctl.io_val[i] : ctl.probe_val[i];
  end

  always_comb begin
    cur_next = cur_reg;
    cur_next.out = out_w;
    cur_next.oe = ctl.drv_en;
    cur_next.level = pin_in;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign pin_out = cur_reg.out;
  assign pin_oe = cur_reg.oe;
  assign ctl.level = cur_reg.level;

endmodule // pin_io_block
`default_nettype wire

/* verilog/pins_if.sv */
// Carrier between the control block and its pin driver.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface pins_if;
  logic [5:0] drv_en;
  logic [5:0] io_val;
  logic [5:0] probe_val;
  logic io_mode;
  logic [5:0] level;
  modport ctrl (output drv_en, output io_val, output probe_val, output io_mode,
    input level);
  modport pins (input drv_en, input io_val, input probe_val, input io_mode,
    output level);
endinterface
`default_nettype wire

/* verilog/test_port_ctrl.sv */
// Test-page control: test pins, probe bus view, receiver and self-test bits.
// Assumes a host register port on clk and pins synchronous to clk.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module test_port_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // Host interface status
  input wire logic host_serial_active,
  // Internal probe buses, bus n in bits 8n+7 to 8n
  input wire logic [255:0] probe_buses,
  // Checksum command pulse from the command decoder
  input wire logic checksum_calc_command,
  // Test-port data pins, D6 down to D1
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe,
  // Auxiliary UART line enables
  output logic uart_aux_tx_en,
  output logic uart_data_req_en,
  // Receiver control
  output logic rx_nonlinear,
  // Type B delimiter lengths in clock cycles
  output logic [11:0] sof_high_len,
  output logic [11:0] sof_low_len,
  output logic [11:0] eof_low_len,
  // Self-test
  output logic self_test_enabled,
  output logic self_test_start
);

  //////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic uart_line_enable;
    logic [5:0] pin_driver_enable_field;
    logic io_use_bit;
    logic [5:0] pin_value_field;
    logic [4:0] probe_bus_select;
    logic receiver_amplify_bit;
    logic frame_delimiter_adjust;
    logic frame_delimiter_width;
    logic [3:0] self_check_field;
    logic [7:0] bus_status;
    logic [7:0] rdata;
    logic uart_en;
    logic rx_amp;
    logic [11:0] sof_hi;
    logic [11:0] sof_lo;
    logic [11:0] eof_lo;
    logic st_en;
    logic st_start;
  } state_t;

  state_t cur_reg;
  state_t cur_next;

  pins_if pins ();

  //////////////////////////////////////////////////////////////////////////
  // Pin driver.

  pin_io_block u_pins (
    .clk(clk),
    .resetn(resetn),
    .ctl(pins.pins),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  // Only a serial host lets the port act as I/O.
  logic io_mode;

  assign io_mode = cur_reg.io_use_bit & host_serial_active;

  assign pins.drv_en = cur_reg.pin_driver_enable_field;
  assign pins.io_val = cur_reg.pin_value_field;
  assign pins.io_mode = io_mode;
  assign pins.probe_val =
    cur_reg.bus_status[test_port_pkg::FIELD_LSB +: test_port_pkg::PIN_N];

  // Probe buses as an array of words, one per selectable bus.
  logic [7:0] probe_word [test_port_pkg::BUS_N];

  for (genvar b = 0; b < test_port_pkg::BUS_N; b++) begin : g_probe
    assign probe_word[b] = probe_buses[b*test_port_pkg::DATA_W +: test_port_pkg::DATA_W];
  end

  // Registered pin levels, one clock behind the pins themselves.
  logic [5:0] pin_level;
  assign pin_level = pins.level;

  // Any pattern but the key leaves the self-test off, so a stray write cannot arm it.
  logic key_match;
  assign key_match = (cur_reg.self_check_field == test_port_pkg::SELF_TEST_KEY);

  //////////////////////////////////////////////////////////////////////////
  // Address decode and write fields.

  // One hit line per mapped register; the status register has no write path.
  logic hit_probe_sel;
  logic hit_pin_en;
  logic hit_pin_val;
  logic hit_bus_stat;
  logic hit_self_test;
  logic hit_delim;
  logic hit_any;

  assign hit_probe_sel = (addr == test_port_pkg::OFS_PROBE_SEL);
  assign hit_pin_en = (addr == test_port_pkg::OFS_PIN_EN);
  assign hit_pin_val = (addr == test_port_pkg::OFS_PIN_VAL);
  assign hit_bus_stat = (addr == test_port_pkg::OFS_BUS_STAT);
  assign hit_self_test = (addr == test_port_pkg::OFS_SELF_TEST);
  assign hit_delim = (addr == test_port_pkg::OFS_DELIM);
  assign hit_any = hit_probe_sel | hit_pin_en | hit_pin_val | hit_bus_stat |
    hit_self_test | hit_delim;

  // Fields of the write data at their register positions.
  logic [5:0] wr_pin_field;
  logic [4:0] wr_sel_field;
  logic [3:0] wr_check_field;

  assign wr_pin_field = wdata[test_port_pkg::FIELD_LSB +: test_port_pkg::PIN_N];
  assign wr_sel_field = wdata[test_port_pkg::SEL_W-1:0];
  assign wr_check_field = wdata[3:0];

  //////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Read-back of one register; unmapped addresses read zero.
  function automatic logic [7:0] read_mux(input state_t s, input logic [5:0] a,
                                          input logic use_pins,
                                          input logic [5:0] lvl);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      test_port_pkg::OFS_PROBE_SEL: begin
        r[test_port_pkg::SEL_W-1:0] = s.probe_bus_select;
      end
      test_port_pkg::OFS_PIN_EN: begin
        r[test_port_pkg::UART_EN_BIT] = s.uart_line_enable;
        r[test_port_pkg::FIELD_LSB +: test_port_pkg::PIN_N] = s.pin_driver_enable_field;
      end
      test_port_pkg::OFS_PIN_VAL: begin
        r[test_port_pkg::IO_USE_BIT] = s.io_use_bit;
        if (use_pins) begin
          r[test_port_pkg::FIELD_LSB +: test_port_pkg::PIN_N] = lvl;
        end else begin
          r[test_port_pkg::FIELD_LSB +: test_port_pkg::PIN_N] = s.pin_value_field;
        end
      end
      test_port_pkg::OFS_BUS_STAT: begin
        r = s.bus_status;
      end
      test_port_pkg::OFS_SELF_TEST: begin
        r[test_port_pkg::AMP_BIT] = s.receiver_amplify_bit;
        r[test_port_pkg::ADJ_BIT] = s.frame_delimiter_adjust;
        r[3:0] = s.self_check_field;
      end
      test_port_pkg::OFS_DELIM: begin
        r[test_port_pkg::DELIM_W_BIT] = s.frame_delimiter_width;
      end
      default: begin
        r = 8'h00;
      end
    endcase
    return r;
  endfunction

  // Delimiter lengths from the adjust and width bits: SOF high, SOF low, EOF low.
  function automatic logic [35:0] delim_len(input logic adj, input logic wid);
    logic [35:0] d;
    d = '0;
    unique case ({adj, wid})
      2'b11: begin
        d = {test_port_pkg::SOF_HI_ADJ, test_port_pkg::LOW_ADJ,
             test_port_pkg::LOW_ADJ};
      end
      2'b01: begin
        d = {test_port_pkg::SOF_HI_MAX, test_port_pkg::LOW_MAX,
             test_port_pkg::LOW_MAX};
      end
      2'b00: begin
        d = {test_port_pkg::SOF_HI_MIN, test_port_pkg::LOW_MIN,
             test_port_pkg::LOW_MIN};
      end
      2'b10: begin
        // Adjust without width has no length of its own; it falls back to the minimum.
        d = {test_port_pkg::SOF_HI_MIN, test_port_pkg::LOW_MIN,
             test_port_pkg::LOW_MIN};
      end
    endcase
    return d;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Next state.

  logic [35:0] lens;

  always_comb begin
    cur_next = cur_reg;
    lens = '0;

    // Register writes; reserved bits are simply not stored.
    if (wr_en && hit_probe_sel) begin
      cur_next.probe_bus_select = wr_sel_field;
    end
    if (wr_en && hit_pin_en) begin
      cur_next.uart_line_enable = wdata[test_port_pkg::UART_EN_BIT];
      cur_next.pin_driver_enable_field = wr_pin_field;
    end
    if (wr_en && hit_pin_val) begin
      cur_next.io_use_bit = wdata[test_port_pkg::IO_USE_BIT];
      cur_next.pin_value_field = wr_pin_field;
    end
    if (wr_en && hit_self_test) begin
      cur_next.receiver_amplify_bit = wdata[test_port_pkg::AMP_BIT];
      cur_next.frame_delimiter_adjust = wdata[test_port_pkg::ADJ_BIT];
      cur_next.self_check_field = wr_check_field;
    end
    if (wr_en && hit_delim) begin
      cur_next.frame_delimiter_width = wdata[test_port_pkg::DELIM_W_BIT];
    end

    cur_next.bus_status = probe_word[cur_reg.probe_bus_select];

    // Read data stands for exactly one cycle after the strobe, and is zero
    // for an address that maps no register.
    if (rd_en && hit_any) begin
      cur_next.rdata = read_mux(cur_reg, addr, io_mode, pin_level);
    end else begin
      cur_next.rdata = 8'h00;
    end

    cur_next.uart_en = cur_reg.uart_line_enable;

    cur_next.rx_amp = cur_reg.receiver_amplify_bit;

    lens = delim_len(cur_reg.frame_delimiter_adjust,
                     cur_reg.frame_delimiter_width);
    cur_next.sof_hi = lens[35:24];
    cur_next.sof_lo = lens[23:12];
    cur_next.eof_lo = lens[11:0];

    cur_next.st_en = key_match;

    cur_next.st_start = checksum_calc_command && key_match;
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers.

  // Derived outputs reset to what the stored fields imply; only the probe status copy, reset to zero, steps at release.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_reg <= '0;
      cur_reg.uart_line_enable <= test_port_pkg::PIN_EN_RST[test_port_pkg::UART_EN_BIT];
      cur_reg.pin_driver_enable_field <=
        test_port_pkg::PIN_EN_RST[test_port_pkg::FIELD_LSB +: test_port_pkg::PIN_N];
      cur_reg.io_use_bit <= test_port_pkg::PIN_VAL_RST[test_port_pkg::IO_USE_BIT];
      cur_reg.pin_value_field <=
        test_port_pkg::PIN_VAL_RST[test_port_pkg::FIELD_LSB +: test_port_pkg::PIN_N];
      cur_reg.probe_bus_select <= test_port_pkg::PROBE_SEL_RST;
      cur_reg.receiver_amplify_bit <= test_port_pkg::SELF_TEST_RST[test_port_pkg::AMP_BIT];
      cur_reg.frame_delimiter_adjust <= test_port_pkg::SELF_TEST_RST[test_port_pkg::ADJ_BIT];
      cur_reg.frame_delimiter_width <= test_port_pkg::DELIM_W_RST;
      cur_reg.self_check_field <= test_port_pkg::SELF_TEST_RST[3:0];
      cur_reg.uart_en <= test_port_pkg::PIN_EN_RST[test_port_pkg::UART_EN_BIT];
      cur_reg.rx_amp <= test_port_pkg::SELF_TEST_RST[test_port_pkg::AMP_BIT];
      cur_reg.sof_hi <= test_port_pkg::SOF_HI_MAX;
      cur_reg.sof_lo <= test_port_pkg::LOW_MAX;
      cur_reg.eof_lo <= test_port_pkg::LOW_MAX;
    end else begin
      cur_reg <= cur_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Register read port.
  assign rdata = cur_reg.rdata;

  // Both auxiliary UART lines follow the one line enable.
  assign uart_aux_tx_en = cur_reg.uart_en;
  assign uart_data_req_en = cur_reg.uart_en;

  // Receiver and frame delimiter controls.
  assign rx_nonlinear = cur_reg.rx_amp;
  assign sof_high_len = cur_reg.sof_hi;
  assign sof_low_len = cur_reg.sof_lo;
  assign eof_low_len = cur_reg.eof_lo;

  // Self-test.
  assign self_test_enabled = cur_reg.st_en;
  assign self_test_start = cur_reg.st_start;

endmodule // test_port_ctrl
`default_nettype wire

/* verilog/test_port_pkg.sv */
// Constants of the test-page control block: register map, field layout,
// reset values and frame delimiter timing.
// Assumes a byte-wide host register port with six address bits.
package test_port_pkg;

  // Register bus shape.
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int PIN_N = 6;
  localparam int SEL_W = 5;
  localparam int BUS_N = 32;

  // Register offsets.
  localparam logic [5:0] OFS_PROBE_SEL = 6'h32;
  localparam logic [5:0] OFS_PIN_EN = 6'h33;
  localparam logic [5:0] OFS_PIN_VAL = 6'h34;
  localparam logic [5:0] OFS_BUS_STAT = 6'h35;
  localparam logic [5:0] OFS_SELF_TEST = 6'h36;
  localparam logic [5:0] OFS_DELIM = 6'h3e;

  // Field positions.
  localparam int UART_EN_BIT = 7;
  localparam int IO_USE_BIT = 7;
  localparam int FIELD_LSB = 1;
  localparam int AMP_BIT = 6;
  localparam int ADJ_BIT = 4;
  localparam int DELIM_W_BIT = 0;

  // Reset values.
  localparam logic [7:0] PIN_EN_RST = 8'h80;
  localparam logic [7:0] PIN_VAL_RST = 8'h00;
  localparam logic [7:0] SELF_TEST_RST = 8'h40;
  localparam logic [4:0] PROBE_SEL_RST = 5'h00;
  localparam logic DELIM_W_RST = 1'b1;

  // Self-test key patterns.
  localparam logic [3:0] SELF_TEST_KEY = 4'h9;
  localparam logic [3:0] SELF_TEST_OFF = 4'h0;

  // Frame delimiter timing, in clock cycles.
  localparam int LEN_W = 12;
  localparam int ETU_CYCLES = 128;
  localparam int ADJ_CYCLES = 8;
  localparam logic [11:0] SOF_HI_MIN = 12'(2 * ETU_CYCLES);
  localparam logic [11:0] SOF_HI_MAX = 12'(3 * ETU_CYCLES);
  localparam logic [11:0] LOW_MIN = 12'(10 * ETU_CYCLES);
  localparam logic [11:0] LOW_MAX = 12'(11 * ETU_CYCLES);
  localparam logic [11:0] SOF_HI_ADJ = 12'(2 * ETU_CYCLES + ADJ_CYCLES);
  localparam logic [11:0] LOW_ADJ = 12'(11 * ETU_CYCLES - ADJ_CYCLES);

endpackage
